// File: design/adc_scan_sequencer.sv
// channel scan sequencer with register port and conversion handshake
`timescale 1ns/100ps
`default_nettype none
module adc_scan_sequencer (
	// clock, reset, enable
	input  wire logic                        CLK_I,
	input  wire logic                        RST_N_I,
	input  wire logic                        CE_I,
	// register port
	input  wire logic [scan_pkg::ADDR_W-1:0] ADDR_I,
	input  wire logic [scan_pkg::DATA_W-1:0] WDATA_I,
	input  wire logic                        WR_I,
	input  wire logic                        RD_I,
	output logic      [scan_pkg::DATA_W-1:0] RDATA_O,
	// host frame pin (external clock pacing)
	input  wire logic                        FRAME_I,
	// converter handshake
	output logic                             CONV_REQ_O,
	output logic      [scan_pkg::CH_W-1:0]   CONV_CH_O,
	input  wire logic                        CONV_DONE_I,
	input  wire logic [scan_pkg::RES_W-1:0]  CONV_DATA_I,
	// result stream toward the fifo
	output logic                             RES_VALID_O,
	output logic      [scan_pkg::RES_W-1:0]  RES_DATA_O,
	output logic      [scan_pkg::CH_W-1:0]   RES_CH_O,
	output logic                             SCAN_DONE_O
);
	import scan_pkg::*;

	logic [DATA_W-1:0] mode_q;
	logic [7:0]        en_low_q, en_high_q;
	logic [DATA_W-1:0] rdata_q;
	seq_state_t        state_q;
	logic [CH_W-1:0]   ch_q;
	logic [CNT_W-1:0]  count_q;
	logic              done_q, busy_q;
	logic              res_v_q;
	logic [RES_W-1:0]  res_d_q;
	logic [CH_W-1:0]   res_ch_q;
	logic [2:0]        frm_q;
	avg_if             avg ();

	// mode word decode
	wire [CH_W-1:0]   start_channel_select = mode_q[F_CHSEL_LO +: CH_W];     // [R2]
	wire [2:0]        scan_field  = mode_q[F_SCAN_LO +: 3];
	wire [AVG_W-1:0]  avg_field   = mode_q[F_AVG_LO +: AVG_W];
	wire              avg_enable  = mode_q[F_AVG_EN];
	wire [1:0]        parts_field = mode_q[F_PARTS_LO +: 2];
	wire [4:0]        top_count   = (parts_field == 2'b01) ? PART_8 :
	                                (parts_field == 2'b10) ? PART_4 : PART_16;
	wire              ext_mode    = (scan_field == SCAN_UPPER_EXT) ||
	                                (scan_field == SCAN_CUST_EXT);
	wire              cust_mode   = (scan_field == SCAN_CUST_INT) ||
	                                (scan_field == SCAN_CUST_EXT);
	wire              mode_valid  = (scan_field != SCAN_IDLE) &&
	                                (scan_field <= SCAN_CUST_EXT);
	wire              use_avg     = avg_enable && !ext_mode;                 // [R4] [R5] [R9]
	wire [15:0]       custom_channel_enable = {en_high_q, en_low_q};         // [R8]

	// register decode
	wire wr_mode = WR_I && (ADDR_I == OFS_MODE);
	wire wr_enl  = WR_I && (ADDR_I == OFS_EN_LOW);
	wire wr_enh  = WR_I && (ADDR_I == OFS_EN_HIGH);

	// next channel search: enabled channel above the current one
	logic [CH_W-1:0] next_ch;
	logic            next_ok;
	wire  [4:0]      upper_lim = top_count;
	always_comb begin
		next_ok = 1'b0;
		next_ch = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (5'(i) > 5'(ch_q) && 5'(i) < upper_lim) begin
				if (!cust_mode || custom_channel_enable[i]) begin            // [R6]
					next_ok = 1'b1;
					next_ch = CH_W'(i);
				end
			end
		end
	end

	// first channel of a scan
	logic [CH_W-1:0] first_ch;
	logic            first_ok;
	always_comb begin
		first_ok = 1'b0;
		first_ch = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (5'(i) < upper_lim) begin
				if (cust_mode ? custom_channel_enable[i]
				              : (CH_W'(i) >= start_channel_select)) begin  // [R1]
					first_ok = 1'b1;
					first_ch = CH_W'(i);
				end
			end
		end
	end

	// host frame pin synchroniser; a level counts once the last two stages agree
	logic frame_lvl_q;
	wire  frame_agree = (frm_q[1] == frm_q[2]);
	wire  frame_rise  = frame_agree && frm_q[2] && !frame_lvl_q;
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			frm_q       <= '0;
			frame_lvl_q <= 1'b0;
		end else if (CE_I) begin
			frm_q <= {frm_q[1:0], FRAME_I};
			if (frame_agree) frame_lvl_q <= frm_q[2];
		end
	end

	// registers written by software
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mode_q    <= MODE_RST;
			en_low_q  <= EN_RST;
			en_high_q <= EN_RST;
		end else if (CE_I) begin
			if (wr_mode) mode_q <= WDATA_I;
			if (wr_enl) en_low_q  <= WDATA_I[7:0];
			if (wr_enh) en_high_q <= WDATA_I[7:0];
		end
	end

	// read data, one cycle after the strobe
	wire [DATA_W-1:0] rd_mux =
		(ADDR_I == OFS_MODE)    ? mode_q :
		(ADDR_I == OFS_EN_LOW)  ? {8'h00, en_low_q} :
		(ADDR_I == OFS_EN_HIGH) ? {8'h00, en_high_q} :
		(ADDR_I == OFS_STATUS)  ? {12'h000, done_q, busy_q, state_q} :
		(ADDR_I == OFS_COUNT)   ? {11'h000, count_q} : 16'h0000;
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) rdata_q <= '0;
		else if (CE_I) rdata_q <= RD_I ? rd_mux : 16'h0000;
	end
	assign RDATA_O = rdata_q;

	// step conditions; a mean arrives while the next request waits, so that request is held
	wire req_go   = ext_mode ? frame_rise : 1'b1;                            // [R11]
	wire cap_full = (count_q + 5'(1)) >= MAX_CONV;                           // [R7]
	wire samp_in  = CONV_DONE_I && state_q == ST_WAIT;
	wire avg_end  = use_avg && avg.out_valid && state_q == ST_REQ;          // [R4] [R9]
	wire ch_done  = use_avg ? avg_end : samp_in;
	wire res_in   = ch_done;
	wire more_ch  = next_ok && !(cust_mode && cap_full);                     // [R1] [R7]

	// scan state machine
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q <= ST_IDLE;
			ch_q    <= '0;
			count_q <= '0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
		end else if (CE_I && ch_done) begin
			count_q <= count_q + 5'(1);                                       // [R3]
			if (more_ch) begin                                                // [R1] [R7]
				ch_q    <= next_ch;
				state_q <= ST_REQ;
			end else begin
				state_q <= ST_DONE;
			end
		end else if (CE_I) begin
			case (state_q)
				ST_IDLE: begin
					if (wr_mode) done_q <= 1'b0;
					if (mode_valid && !done_q && first_ok && !wr_mode) begin
						ch_q    <= first_ch;
						count_q <= '0;
						busy_q  <= 1'b1;
						state_q <= ST_REQ;
					end
				end
				ST_REQ: begin
					if (req_go) state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					if (samp_in) state_q <= ST_REQ;                         // next sample of the mean
				end
				ST_DONE: begin
					busy_q  <= 1'b0;
					done_q  <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	assign CONV_REQ_O  = (state_q == ST_REQ) && req_go && !avg_end;
	assign CONV_CH_O   = ch_q;
	assign SCAN_DONE_O = done_q;

	// averaging unit hookup
	assign avg.in_valid = use_avg && samp_in;
	assign avg.in_data  = CONV_DATA_I;
	assign avg.start    = (state_q == ST_IDLE);
	assign avg.shift    = avg_field;
	scan_avg u_avg (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CE_I),
		.bus     (avg.avg)
	);

	// result register toward the fifo
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			res_v_q  <= 1'b0;
			res_d_q  <= '0;
			res_ch_q <= '0;
		end else if (CE_I) begin
			res_v_q <= res_in;                                               // [R6]
			if (res_in) begin
				res_d_q  <= use_avg ? avg.out_data : CONV_DATA_I;           // [R5]
				res_ch_q <= ch_q;
			end
		end
	end
	assign RES_VALID_O = res_v_q;
	assign RES_DATA_O  = res_d_q;
	assign RES_CH_O    = res_ch_q;

	// checks
	AST_EXT_PACED: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R11]
		(CONV_REQ_O && ext_mode) |-> frame_rise)
		else $error("external request without host frame");
	AST_CUST_MAX: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R7]
		(busy_q && cust_mode) |-> (count_q <= MAX_CONV))
		else $error("custom scan longer than limit");
	AST_CUST_EN: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R6]
		(CONV_REQ_O && cust_mode) |-> custom_channel_enable[CONV_CH_O])
		else $error("custom scan converts disabled channel");
	AST_UPPER_FROM: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R1]
		(CONV_REQ_O && !cust_mode) |-> (CONV_CH_O >= start_channel_select))
		else $error("upper scan below start channel");
	AST_UPPER_TOP: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R1]
		CONV_REQ_O |-> (5'(CONV_CH_O) < top_count))
		else $error("channel beyond part top");
	AST_NO_AVG_EXT: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R5]
		(ext_mode && CE_I && samp_in) |=> (RES_VALID_O && RES_DATA_O == $past(CONV_DATA_I)))
		else $error("external result altered");
	AST_UPPER_COUNT: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R3]
		(state_q == ST_DONE && !cust_mode) |->
		(count_q == top_count - 5'(start_channel_select)))
		else $error("upper scan result count wrong");
	// last stored channel of the running scan, for the order check
	logic [CH_W-1:0] prev_ch_q;
	logic            prev_v_q;
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			prev_ch_q <= '0;
			prev_v_q  <= 1'b0;
		end else if (CE_I) begin
			if (state_q == ST_IDLE) begin
				prev_v_q <= 1'b0;
			end else if (RES_VALID_O) begin
				prev_v_q  <= 1'b1;
				prev_ch_q <= RES_CH_O;
			end
		end
	end
	sequence s_mean_store;
		!CONV_REQ_O ##1 RES_VALID_O;
	endsequence
	AST_AVG_STORE: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R4] [R9]
		(CE_I && avg_end) |-> s_mean_store)
		else $error("mean not stored or extra request");
	AST_ASCEND: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [R6]
		(RES_VALID_O && prev_v_q) |-> (RES_CH_O > prev_ch_q))
		else $error("results out of ascending order");
endmodule : adc_scan_sequencer
`default_nettype wire

// File: design/scan_pkg.sv
// constants and types shared by the scan sequencer files
// Notes on behaviour
// [R1] upper scans convert from start channel rising through the top channel
// [R2] start channel comes from the four-bit start channel select field
// [R3] upper scan from N stores channels-minus-N results (16, 8 or 4 channel parts)
// [R4] internal-clock upper scan may average each channel before storing
// [R5] external-clock upper scan never averages; each result passes as is
// [R6] custom scans convert only enabled channels, ascending, each result stored
// [R7] a custom sequence holds at most sixteen conversions
// [R8] custom channel set comes from two host-written enable registers
// [R9] internal-clock custom scan may average each enabled channel
// [R10] host writes enables and start channel before selecting a scan mode
// [R11] external-clock scans step once per host frame, not the internal oscillator
`default_nettype none
package scan_pkg;
	localparam int           ADDR_W        = 4;
	localparam int           DATA_W        = 16;
	localparam int           CH_W          = 4;
	localparam int           RES_W         = 12;
	localparam int           NUM_CH        = 16;
	localparam int           AVG_W         = 3;
	localparam int           CNT_W         = 5;
	// register offsets
	localparam logic [3:0]   OFS_MODE      = 4'h0;
	localparam logic [3:0]   OFS_EN_LOW    = 4'h1;
	localparam logic [3:0]   OFS_EN_HIGH   = 4'h2;
	localparam logic [3:0]   OFS_STATUS    = 4'h3;
	localparam logic [3:0]   OFS_COUNT     = 4'h4;
	// mode word fields
	localparam int           F_CHSEL_LO    = 0;
	localparam int           F_SCAN_LO     = 4;
	localparam int           F_AVG_LO      = 7;
	localparam int           F_AVG_EN      = 10;
	localparam int           F_PARTS_LO    = 11;
	localparam logic [15:0]  MODE_RST      = 16'h0000;
	localparam logic [7:0]   EN_RST        = 8'h00;
	localparam logic [4:0]   MAX_CONV      = 5'h10;
	// part channel counts
	localparam logic [4:0]   PART_16       = 5'h10;
	localparam logic [4:0]   PART_8        = 5'h08;
	localparam logic [4:0]   PART_4        = 5'h04;
	typedef enum logic [2:0] {
		SCAN_IDLE      = 3'b000,
		SCAN_UPPER_INT = 3'b001,
		SCAN_UPPER_EXT = 3'b010,
		SCAN_CUST_INT  = 3'b011,
		SCAN_CUST_EXT  = 3'b100
	} scan_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ  = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} seq_state_t;
endpackage : scan_pkg
`default_nettype wire

// File: design/avg_if.sv
// interface between sequencer and averaging unit
`timescale 1ns/100ps
`default_nettype none
interface avg_if;
	import scan_pkg::*;
	logic              in_valid;
	logic [RES_W-1:0]  in_data;
	logic              start;
	logic [AVG_W-1:0]  shift;
	logic              out_valid;
	logic [RES_W-1:0]  out_data;
	modport seq (output in_valid, in_data, start, shift, input out_valid, out_data);
	modport avg (input in_valid, in_data, start, shift, output out_valid, out_data);
endinterface : avg_if
`default_nettype wire

// File: design/scan_avg.sv
// per-channel result averaging unit
`timescale 1ns/100ps
`default_nettype none
module scan_avg (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	avg_if.avg        bus
);
	import scan_pkg::*;
	localparam int ACC_W = RES_W + 8;
	logic [ACC_W-1:0] acc_q;
	logic [7:0]       n_q;
	logic [RES_W-1:0] out_q;
	logic             ov_q;
	wire  [7:0]       n_total = 8'(1) << bus.shift;
	wire  [ACC_W-1:0] acc_sum = acc_q + ACC_W'(bus.in_data);
	wire              last    = bus.in_valid && (n_q + 8'(1) == n_total);

	// accumulate 2^shift samples, emit the mean
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_q <= '0;
			n_q   <= '0;
			out_q <= '0;
			ov_q  <= 1'b0;
		end else if (ce_i) begin
			ov_q <= last;
			if (bus.start) begin
				acc_q <= '0;
				n_q   <= '0;
			end else if (last) begin
				out_q <= RES_W'(acc_sum >> bus.shift);
				acc_q <= '0;
				n_q   <= '0;
			end else if (bus.in_valid) begin
				acc_q <= acc_sum;
				n_q   <= n_q + 8'(1);
			end
		end
	end
	assign bus.out_valid = ov_q;
	assign bus.out_data  = out_q;
endmodule : scan_avg
`default_nettype wire

// File: dv/conv_model.sv
// converter stand-in answering each conversion request
`timescale 1ns/100ps
`default_nettype none
module conv_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// answer pacing
	input  wire logic        slow_i,
	// request side
	input  wire logic        req_i,
	input  wire logic [3:0]  ch_i,
	// answer side
	output logic             done_o,
	output logic      [11:0] data_o
);
	logic       busy_q;
	logic [2:0] wait_q;
	logic [3:0] ch_q;
	logic       alt_q;
	// one answer per request; data toggles on every cycle but the answer cycle so nothing stale is seen
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{busy_q, wait_q, ch_q, alt_q, done_o} <= '0;
			data_o <= 12'h0fff;
		end else begin
			done_o <= 1'b0;
			data_o <= ~data_o;
			if (req_i) begin
				busy_q <= 1'b1;
				ch_q   <= ch_i;
				wait_q <= slow_i ? 3'd4 : 3'd0;
			end else if (busy_q && wait_q != 3'd0) begin
				wait_q <= wait_q - 3'd1;
			end else if (busy_q) begin
				busy_q <= 1'b0;
				done_o <= 1'b1;
				alt_q  <= ~alt_q;
				data_o <= {ch_q, 6'h00, alt_q, 1'b0}; // two samples average to base plus one
			end
		end
	end
endmodule : conv_model
`default_nettype wire

// File: dv/test_adc_scan_sequencer.sv
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module test_adc_scan_sequencer;
	import scan_pkg::*;
	logic        clk, rst_n, ce, wr_s, rd_s, frame, slow, req, done, rv, sdone;
	logic [3:0]  addr, ch, rch;
	logic [15:0] wdata, rdata, q;
	logic [11:0] cdata, rdat;
	logic [3:0]  got_ch[$];
	logic [11:0] got_dat[$];
	logic [3:0]  exp[$];
	int          n_req, failures, n_tests;
	adc_scan_sequencer i_adc_scan_sequencer (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
		.FRAME_I(frame), .CONV_REQ_O(req), .CONV_CH_O(ch), .CONV_DONE_I(done),
		.CONV_DATA_I(cdata), .RES_VALID_O(rv), .RES_DATA_O(rdat), .RES_CH_O(rch),
		.SCAN_DONE_O(sdone));
	conv_model i_conv_model (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .req_i(req),
		.ch_i(ch), .done_o(done), .data_o(cdata));
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// result and request monitor
	always @(posedge clk) begin
		if (rv === 1'b1) begin
			got_ch.push_back(rch);
			got_dat.push_back(rdat);
		end
		if (req === 1'b1) n_req++;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk); // idle cycle keeps strobes apart and lets status settle
	endtask : wr
	task automatic rd(input logic [3:0] a);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		q = rdata; // read data stand in this cycle only
		@(posedge clk);
	endtask : rd
	function automatic logic [15:0] mw(input logic [1:0] p, input logic ae,
		input logic [2:0] sc, input logic [3:0] c);
		mw = {3'b000, p, ae, 3'b001, sc, c};
	endfunction : mw
	// one scan: write mode, pace frames if external, then judge the results
	task automatic run_scan(input logic [15:0] m, input bit ext, input bit avg);
		int k;
		got_ch.delete();
		got_dat.delete();
		n_req = 0;
		wr(OFS_MODE, m);
		if (ext) begin
			repeat (20) @(posedge clk);
			chk(16'(n_req), 16'h0000);
		end
		k = 0;
		while (sdone !== 1'b1 && k < 3000) begin
			frame <= ext && (k % 12 < 4);
			@(posedge clk);
			k++;
		end
		frame <= 1'b0;
		chk(16'(k < 3000), 16'h0001);
		chk(16'(got_ch.size()), 16'(exp.size()));
		chk(16'(n_req), 16'(exp.size() << avg));
		foreach (exp[i]) begin
			chk(16'(got_ch[i]), 16'(exp[i]));
			chk(16'(got_dat[i] & (avg ? 12'hfff : 12'hff0)), 16'({exp[i], 7'h00, avg}));
		end
		rd(OFS_COUNT);
		chk(16'(q[4:0]), 16'(exp.size()));
	endtask : run_scan
	task automatic t_regs;
		chk(16'({rv, req, sdone}), 16'h0000);
		chk(rdata, 16'h0000);
		rd(OFS_MODE);
		chk(q, MODE_RST);
		rd(OFS_EN_HIGH);
		chk(q, 16'(EN_RST));
		wr(OFS_EN_LOW, 16'h0081);
		wr(OFS_EN_HIGH, 16'h0080);
		rd(OFS_EN_LOW);
		chk(q, 16'h0081);
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		wr(OFS_EN_LOW, 16'h0055);
		ce <= 1'b1;
		rd(OFS_EN_LOW);
		chk(q, 16'h0081);
		rd(4'h9);
		chk(q, 16'h0000);
		$display("test regs done");
	endtask : t_regs
	task automatic t_upper;
		exp = '{4'd14, 4'd15};
		run_scan(mw(2'd0, 1'b0, SCAN_UPPER_INT, 4'd14), 0, 0);
		slow <= 1'b1;
		exp = '{4'd5, 4'd6, 4'd7};
		run_scan(mw(2'd1, 1'b0, SCAN_UPPER_INT, 4'd5), 0, 0);
		slow <= 1'b0;
		exp = '{4'd3};
		run_scan(mw(2'd2, 1'b1, SCAN_UPPER_INT, 4'd3), 0, 1);
		exp = '{4'd2, 4'd3};
		run_scan(mw(2'd2, 1'b1, SCAN_UPPER_EXT, 4'd2), 1, 0);
		$display("test upper done");
	endtask : t_upper
	task automatic t_custom;
		exp = '{4'd0, 4'd7, 4'd15};
		run_scan(mw(2'd0, 1'b1, SCAN_CUST_INT, 4'd9), 0, 1);
		wr(OFS_EN_LOW, 16'h00ff);
		wr(OFS_EN_HIGH, 16'h00ff);
		exp.delete();
		for (int i = 0; i < 16; i++) exp.push_back(4'(i));
		run_scan(mw(2'd0, 1'b1, SCAN_CUST_EXT, 4'd0), 1, 0);
		$display("test custom done");
	endtask : t_custom
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	// watchdog
	initial begin
		#(25 * 40000);
		failures++;
		finish_test();
	end
	// main sequence
	initial begin
		{rst_n, wr_s, rd_s, frame, slow, addr, wdata} = '0;
		ce = 1'b1;
		failures = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_upper();
		t_custom();
		finish_test();
	end
endmodule : test_adc_scan_sequencer
`default_nettype wire
